// *** logic/ssrc_ctrl.sv ***
// Purpose: Shadow set control word and map, with entry and return updates
// Assumes: Entry and return strobes are one-cycle, never both at once
// Notes:   Entry while error level is set leaves sets unchanged
`timescale 1ns/1ns
module ssrc_ctrl (
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        regWrEn,     // Software write strobe
   input  wire logic        regRdEn,     // Software read strobe
   input  wire logic [1:0]  regSel,      // Which register
   input  wire logic [31:0] regWrData,   // Write data
   input  wire logic        excEntry,    // Exception or interrupt taken
   input  wire logic        entryIsIntr, // Entry is an interrupt
   input  wire logic        entrySetsErl, // NMI or cache error
   input  wire logic        debugEntry,  // Entry to debug mode
   input  wire logic        exceptionReturn, // Return executes
   input  wire logic        errorLevelFlag,
   input  wire logic        exceptionLevelFlag,
   input  wire logic        bootVectorSelect,
   input  wire logic        interruptVectorSelect,
   input  wire logic [4:0]  vectorSpacing,
   input  wire logic        extCtrlModePresent,
   input  wire logic        vectoredModePresent,
   input  wire logic [2:0]  vectorIndex,
   input  wire logic        extIntReq,   // Controller request strobe
   input  wire logic [3:0]  extSetIn,    // Set from controller
   output logic [31:0]      regRdData,
   output logic [3:0]       currentSet
);
   // Reset synchroniser, second flop drives the design
   logic rstMeta_q;
   logic rstSync_q;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end

   logic [3:0]  excSet_q;   // Exception set
   logic [3:0]  prevSet_q;  // Previous set
   logic [3:0]  curSet_q;   // Current set
   logic [3:0]  extSet_q;   // External controller set
   logic [31:0] mapWord;    // Map contents
   logic [3:0]  mapSet;     // Map lookup
   logic [3:0]  newSet;     // Selected entry set
   logic        shadowsOn;  // Shadow sets implemented
   logic        entryTakes; // Entry updates sets
   logic        retTakes;   // Return restores current
   logic        ctlWr;      // Control word write this cycle
   logic        mapWr;      // Map write this cycle

   assign shadowsOn = (ssrc_pkg::HSS_PRESET != 4'h0);
   assign ctlWr = regWrEn && (regSel == ssrc_pkg::SEL_CTL);
   // Map access is undefined without shadows; writes simply dropped
   assign mapWr = regWrEn && (regSel == ssrc_pkg::SEL_MAP) && shadowsOn;

   // Entry is excluded under any error, debug, level or boot condition
   assign entryTakes = excEntry && shadowsOn && !entrySetsErl &&
                       !debugEntry && !exceptionLevelFlag &&
                       !bootVectorSelect && !errorLevelFlag;
   assign retTakes = exceptionReturn && shadowsOn &&
                     !errorLevelFlag && !bootVectorSelect;

   // Error-level entries, raised or already set, move neither current nor previous set
   erlKeep_a: assert property (@(posedge clk_sys)
      disable iff (!rstSync_q)
      (excEntry && (errorLevelFlag || entrySetsErl) &&
       !exceptionReturn && !ctlWr) |=>
      $stable(curSet_q) && $stable(prevSet_q))
      else $error("error-level entry changed sets");
   // Return while boot vectors are selected keeps current set
   bootRet_a: assert property (@(posedge clk_sys)
      disable iff (!rstSync_q)
      (exceptionReturn && bootVectorSelect && !excEntry) |=>
      $stable(curSet_q))
      else $error("boot-vector return changed current");

   ssrc_map_mem uMap (
      .clk       (clk_sys),
      .rstSync_n (rstSync_q),
      .wrEn      (mapWr),
      .wrData    (regWrData),
      .lookupIdx (vectorIndex),
      .mapWord   (mapWord),
      .lookupSet (mapSet)
   );

   // Whole-word writes only; no entry can be updated on its own
   // A map write replaces all eight entries at once
   mapWrite_a: assert property (@(posedge clk_sys)
      disable iff (!rstSync_q)
      mapWr |=> mapWord == $past(regWrData))
      else $error("map write lost");

   ssrc_entry_sel uSel (
      .isIntr     (entryIsIntr),
      .ivSel      (interruptVectorSelect),
      .vsNonZero  (vectorSpacing != 5'h00),
      .extPresent (extCtrlModePresent),
      .vecPresent (vectoredModePresent),
      .excSet     (excSet_q),
      .mapSet     (mapSet),
      .extSet     (extSet_q),
      .newSet     (newSet)
   );

   // Exception set: software writable only with shadows present
   always_ff @(posedge clk_sys or negedge rstSync_q) begin
      if (!rstSync_q) begin
         excSet_q <= ssrc_pkg::SET_RST;
      end else if (ctlWr && shadowsOn) begin
         excSet_q <= regWrData[ssrc_pkg::CTL_ESS_LO +: 4];
      end
   end

   // A control write reaches the exception set on the next edge
   excWrite_a: assert property (@(posedge clk_sys)
      disable iff (!rstSync_q)
      (ctlWr && shadowsOn) |=>
      excSet_q == $past(regWrData[ssrc_pkg::CTL_ESS_LO +: 4]))
      else $error("exception set write lost");

   // External set: loaded per request only in external mode
   always_ff @(posedge clk_sys or negedge rstSync_q) begin
      if (!rstSync_q) begin
         extSet_q <= ssrc_pkg::SET_RST;
      end else if (!extCtrlModePresent) begin
         extSet_q <= ssrc_pkg::SET_RST;
      end else if (extIntReq) begin
         extSet_q <= extSetIn;
      end
   end

   // External set follows each controller request in external mode
   extLoad_a: assert property (@(posedge clk_sys)
      disable iff (!rstSync_q)
      (extCtrlModePresent && extIntReq) |=> extSet_q == $past(extSetIn))
      else $error("external set not loaded");
   // Between requests the external field holds its value
   extHold_a: assert property (@(posedge clk_sys)
      disable iff (!rstSync_q)
      (extCtrlModePresent && !extIntReq) |=> $stable(extSet_q))
      else $error("external set moved without request");

   // Previous set: entry capture has priority over software write
   always_ff @(posedge clk_sys or negedge rstSync_q) begin
      if (!rstSync_q) begin
         prevSet_q <= ssrc_pkg::SET_RST;
      end else if (entryTakes) begin
         prevSet_q <= curSet_q;
      end else if (ctlWr && shadowsOn) begin
         prevSet_q <= regWrData[ssrc_pkg::CTL_PSS_LO +: 4];
      end
   end

   // Trade-off: a write racing an entry is lost; handlers rewrite it
   // Without a competing entry a control write lands in previous set
   prevWrite_a: assert property (@(posedge clk_sys)
      disable iff (!rstSync_q)
      (ctlWr && shadowsOn && !entryTakes) |=>
      prevSet_q == $past(regWrData[ssrc_pkg::CTL_PSS_LO +: 4]))
      else $error("previous set write lost");

   // Current set: never written by software directly
   always_ff @(posedge clk_sys or negedge rstSync_q) begin
      if (!rstSync_q) begin
         curSet_q <= ssrc_pkg::SET_RST;
      end else if (entryTakes) begin
         curSet_q <= newSet;
      end else if (retTakes) begin
         curSet_q <= prevSet_q;
      end
   end

   // Source checks use the map word, not the lookup, to catch index slips
   // Vectored interrupt without a controller takes its map nibble
   mapSrc_a: assert property (@(posedge clk_sys)
      disable iff (!rstSync_q)
      (entryTakes && entryIsIntr && interruptVectorSelect &&
       vectorSpacing != 5'h00 && !extCtrlModePresent &&
       vectoredModePresent) |=>
      curSet_q == $past(mapWord[vectorIndex * 4 +: 4]))
      else $error("vectored entry missed its map entry");
   // Vectored interrupt with a controller takes the external set
   extSrc_a: assert property (@(posedge clk_sys)
      disable iff (!rstSync_q)
      (entryTakes && entryIsIntr && interruptVectorSelect &&
       vectorSpacing != 5'h00 && extCtrlModePresent) |=>
      curSet_q == $past(extSet_q))
      else $error("external entry missed controller set");
   // Non-vectored interrupt is handled like an exception
   nonVecSrc_a: assert property (@(posedge clk_sys)
      disable iff (!rstSync_q)
      (entryTakes && entryIsIntr &&
       (!interruptVectorSelect || vectorSpacing == 5'h00)) |=>
      curSet_q == $past(excSet_q))
      else $error("non-vectored entry wrong source");

   // Registered read mux; reserved bits stay zero
   always_ff @(posedge clk_sys or negedge rstSync_q) begin
      if (!rstSync_q) begin
         regRdData <= 32'h00000000;
      end else if (regRdEn) begin
         regRdData <= 32'h00000000;
         if (regSel == ssrc_pkg::SEL_CTL) begin
            regRdData[ssrc_pkg::CTL_ESS_LO +: 4] <= excSet_q;
            regRdData[ssrc_pkg::CTL_HSS_LO +: 4] <=
               ssrc_pkg::HSS_PRESET;
            regRdData[ssrc_pkg::CTL_EXT_CTRL_SET_NUMBER_LO +: 4] <= extSet_q;
            regRdData[ssrc_pkg::CTL_PSS_LO +: 4] <= prevSet_q;
            regRdData[ssrc_pkg::CTL_CSS_LO +: 4] <= curSet_q;
         end else if (regSel == ssrc_pkg::SEL_MAP) begin
            regRdData <= mapWord;
         end
      end
   end

   // Readout checks: each field shows its flop as of the read edge
   // Current set reads back as held, never as written
   cssRead_a: assert property (@(posedge clk_sys)
      disable iff (!rstSync_q)
      (regRdEn && regSel == ssrc_pkg::SEL_CTL) |=>
      regRdData[ssrc_pkg::CTL_CSS_LO +: 4] == $past(curSet_q))
      else $error("current set readout wrong");
   // A captured previous set is seen by the very next read
   prevRead_a: assert property (@(posedge clk_sys)
      disable iff (!rstSync_q)
      (regRdEn && regSel == ssrc_pkg::SEL_CTL) |=>
      regRdData[ssrc_pkg::CTL_PSS_LO +: 4] == $past(prevSet_q))
      else $error("previous set readout wrong");
   // External set field shows the last controller value
   extRead_a: assert property (@(posedge clk_sys)
      disable iff (!rstSync_q)
      (regRdEn && regSel == ssrc_pkg::SEL_CTL) |=>
      regRdData[ssrc_pkg::CTL_EXT_CTRL_SET_NUMBER_LO +: 4] == $past(extSet_q))
      else $error("external set readout wrong");
   // Exception set field shows the stored value
   essRead_a: assert property (@(posedge clk_sys)
      disable iff (!rstSync_q)
      (regRdEn && regSel == ssrc_pkg::SEL_CTL) |=>
      regRdData[ssrc_pkg::CTL_ESS_LO +: 4] == $past(excSet_q))
      else $error("exception set readout wrong");
   // Map readout is the whole word, entry seven on top
   mapRead_a: assert property (@(posedge clk_sys)
      disable iff (!rstSync_q)
      (regRdEn && regSel == ssrc_pkg::SEL_MAP) |=>
      regRdData == $past(mapWord))
      else $error("map readout wrong");
   // Unused selects read as all zeros
   otherZero_a: assert property (@(posedge clk_sys)
      disable iff (!rstSync_q)
      (regRdEn && regSel[1]) |=> regRdData == 32'h00000000)
      else $error("unused select read nonzero");

   assign currentSet = curSet_q;

   // Entry capture moves old current into previous
   entryCapture_a: assert property (@(posedge clk_sys)
      disable iff (!rstSync_q)
      entryTakes |=> prevSet_q == $past(curSet_q))
      else $error("previous set not captured");
   // Excluded entry keeps both fields
   entryExcl_a: assert property (@(posedge clk_sys)
      disable iff (!rstSync_q)
      (excEntry && (exceptionLevelFlag || bootVectorSelect ||
       debugEntry) && !exceptionReturn && !ctlWr) |=>
      $stable(curSet_q) && $stable(prevSet_q))
      else $error("excluded entry changed sets");
   // Return restores previous
   retRestore_a: assert property (@(posedge clk_sys)
      disable iff (!rstSync_q)
      (retTakes && !excEntry) |=> curSet_q == $past(prevSet_q))
      else $error("return did not restore");
   // Blocked return keeps current
   retBlock_a: assert property (@(posedge clk_sys)
      disable iff (!rstSync_q)
      (exceptionReturn && errorLevelFlag && !excEntry) |=>
      $stable(curSet_q))
      else $error("blocked return changed current");
   // Software write never touches current
   curReadOnly_a: assert property (@(posedge clk_sys)
      disable iff (!rstSync_q)
      (!excEntry && !exceptionReturn) |=> $stable(curSet_q))
      else $error("current set changed by software");
   // Exception entry takes exception set
   excSrc_a: assert property (@(posedge clk_sys)
      disable iff (!rstSync_q)
      (entryTakes && !entryIsIntr) |=> curSet_q == $past(excSet_q))
      else $error("exception entry wrong source");
   // External mode off forces external field zero
   extZero_a: assert property (@(posedge clk_sys)
      disable iff (!rstSync_q)
      !extCtrlModePresent |=> extSet_q == 4'h0)
      else $error("external set not zero");
   // Reserved bits read zero
   rsvdZero_a: assert property (@(posedge clk_sys)
      disable iff (!rstSync_q)
      regRdEn |=> ((regRdData & 32'hc3c30c30) == 32'h00000000 ||
                   $past(regSel) != ssrc_pkg::SEL_CTL))
      else $error("reserved bits nonzero");
   // Highest set reads as preset
   hssRead_a: assert property (@(posedge clk_sys)
      disable iff (!rstSync_q)
      (regRdEn && regSel == ssrc_pkg::SEL_CTL) |=>
      regRdData[29:26] == ssrc_pkg::HSS_PRESET)
      else $error("highest set wrong");

   entryCov_c: cover property (@(posedge clk_sys) entryTakes);
   retCov_c: cover property (@(posedge clk_sys) retTakes);
   vecCov_c: cover property (@(posedge clk_sys)
      entryTakes && entryIsIntr && interruptVectorSelect);
   extCov_c: cover property (@(posedge clk_sys)
      entryTakes && entryIsIntr && extCtrlModePresent);
   exclCov_c: cover property (@(posedge clk_sys) excEntry && !entryTakes);
endmodule // ssrc_ctrl

// *** logic/ssrc_pkg.sv ***
// Purpose: Shared constants for the shadow register set control block
// Assumes: Coprocessor register accesses arrive as one-cycle strobes
// Notes:   Field positions, reset values and select codes live here
package ssrc_pkg;
   // Set number width and entry count
   localparam int SET_W        = 4;
   localparam int MAP_ENTRIES  = 8;
   localparam int VEC_W        = 3;
   // Control word field positions (low bit of each field)
   localparam int CTL_HSS_LO   = 26;
   localparam int CTL_EXT_CTRL_SET_NUMBER_LO = 18;
   localparam int CTL_ESS_LO   = 12;
   localparam int CTL_PSS_LO   = 6;
   localparam int CTL_CSS_LO   = 0;
   // Register selects on the coprocessor access port
   localparam logic [1:0] SEL_CTL   = 2'h0;
   localparam logic [1:0] SEL_MAP   = 2'h1;
   // Reset values
   localparam logic [3:0]  SET_RST  = 4'h0;
   localparam logic [31:0] MAP_RST  = 32'h00000000;
   // Implemented highest set, preset by hardware
   localparam logic [3:0]  HSS_PRESET = 4'hf;
endpackage

// *** logic/ssrc_map_mem.sv ***
// Purpose: Eight-entry vector to set map held in flops
// Assumes: Single writer, whole-word writes
// Notes:   Both read ports show the entry flops; the caller registers
//          the software readout, the lookup feeds entry selection
`timescale 1ns/1ns
module ssrc_map_mem (
   input  wire logic        clk,
   input  wire logic        rstSync_n,
   input  wire logic        wrEn,
   input  wire logic [31:0] wrData,
   input  wire logic [2:0]  lookupIdx,
   output logic [31:0]      mapWord,
   output logic [3:0]       lookupSet
);
   // Entry storage, one nibble per vector
   logic [3:0] entry_q [8];

   // One 4-bit register per entry; duplicates allowed, no uniqueness check
   for (genvar i = 0; i < ssrc_pkg::MAP_ENTRIES; i++) begin : gEnt
      always_ff @(posedge clk or negedge rstSync_n) begin
         if (!rstSync_n) begin
            entry_q[i] <= ssrc_pkg::SET_RST;
         end else if (wrEn) begin
            entry_q[i] <= wrData[i*4 +: 4];
         end
      end
      assign mapWord[i*4 +: 4] = entry_q[i];
   end

   // Selected nibble at index times four
   assign lookupSet = entry_q[lookupIdx];
endmodule // ssrc_map_mem

// *** logic/ssrc_entry_sel.sv ***
// Purpose: Chooses the new current set on exception or interrupt entry
// Assumes: Mode inputs are steady during the entry cycle
// Notes:   Pure combinational selector
`timescale 1ns/1ns
module ssrc_entry_sel (
   input  wire logic       isIntr,
   input  wire logic       ivSel,
   input  wire logic       vsNonZero,
   input  wire logic       extPresent,
   input  wire logic       vecPresent,
   input  wire logic [3:0] excSet,
   input  wire logic [3:0] mapSet,
   input  wire logic [3:0] extSet,
   output logic [3:0]      newSet
);
   // Priority: non-vectored first, then external, then map
   always_comb begin
      if (!isIntr || !ivSel || !vsNonZero) begin
         newSet = excSet;
      end else if (extPresent) begin
         newSet = extSet;
      end else if (vecPresent) begin
         newSet = mapSet;
      end else begin
         newSet = excSet;
      end
   end
endmodule // ssrc_entry_sel

// *** test/ssrc_eic_model.sv ***
// Purpose: External interrupt controller stand-in that hands over set numbers
// Assumes: Bench raises go for one cycle, changing it on the falling clock edge
// Notes:   Set bus carries no stale value between requests
`timescale 1ns/1ns
module ssrc_eic_model (
   input  wire logic       clk_sys,
   input  wire logic       go,        // Bench asks for one request
   input  wire logic [3:0] setVal,    // Set number to deliver
   output logic            extIntReq, // Request strobe to the block
   output logic [3:0]      extSetIn   // Set number for the request
);
   logic [3:0] noise_q = 4'ha;        // Filler shown while idle

   // Idle bus flips every cycle so a late sample cannot match by luck
   always @(posedge clk_sys) begin
      noise_q <= ~noise_q;
   end

   // One request per go, set number valid only alongside the strobe
   assign extIntReq = go;
   assign extSetIn  = go ? setVal : noise_q ^ setVal;
endmodule // ssrc_eic_model

// *** test/ssrc_ctrl_tb.sv ***
// Purpose: Self-checking bench for the shadow set control block
// Assumes: Highest set preset, so every 4-bit set value is legal
// Notes:   Random entries and returns checked against a reference model
`timescale 1ns/1ns
module ssrc_ctrl_tb;
   logic clk_sys = 1'b0, rstn = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0;
   logic [1:0] regSel = 2'h0;
   logic [31:0] regWrData = 32'h0, regRdData, r, r2;
   logic excEntry = 0, entryIsIntr = 0, entrySetsErl = 0, debugEntry = 0;
   logic exceptionReturn = 0, errorLevelFlag = 0, exceptionLevelFlag = 0;
   logic bootVectorSelect = 0, interruptVectorSelect = 0, go = 0;
   logic extCtrlModePresent = 0, vectoredModePresent = 1, extIntReq;
   logic [4:0] vectorSpacing = 5'h0;
   logic [2:0] vectorIndex = 3'h0;
   logic [3:0] extSetIn, currentSet, setVal = 4'h0;
   logic [3:0] exception_set_number = 0, previous_set_number = 0, current_set_number = 0, eic = 0; // Reference fields
   logic [31:0] map = 32'h0;                         // Reference map
   int n_fail = 0, checks = 0, seed = 32'h6675e80f, i;

   always #20 clk_sys = ~clk_sys;

   ssrc_ctrl u_ssrc_ctrl (.clk_sys(clk_sys), .rstn(rstn), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .regSel(regSel), .regWrData(regWrData),
      .excEntry(excEntry), .entryIsIntr(entryIsIntr),
      .entrySetsErl(entrySetsErl), .debugEntry(debugEntry),
      .exceptionReturn(exceptionReturn), .errorLevelFlag(errorLevelFlag),
      .exceptionLevelFlag(exceptionLevelFlag),
      .bootVectorSelect(bootVectorSelect),
      .interruptVectorSelect(interruptVectorSelect),
      .vectorSpacing(vectorSpacing), .extCtrlModePresent(extCtrlModePresent),
      .vectoredModePresent(vectoredModePresent), .vectorIndex(vectorIndex),
      .extIntReq(extIntReq), .extSetIn(extSetIn), .regRdData(regRdData),
      .currentSet(currentSet));
   ssrc_eic_model u_ssrc_eic_model (.clk_sys(clk_sys), .go(go),
      .setVal(setVal), .extIntReq(extIntReq), .extSetIn(extSetIn));

   // Control word as software should see it; external set hidden when off
   function automatic logic [31:0] ctlExp();
      return {2'h0, ssrc_pkg::HSS_PRESET, 4'h0,
              extCtrlModePresent ? eic : 4'h0, 2'h0, exception_set_number, 2'h0, previous_set_number,
              2'h0, current_set_number};
   endfunction

   // New current set chosen on entry
   function automatic logic [3:0] newSet();
      if (!entryIsIntr || !interruptVectorSelect || vectorSpacing == 5'h0)
         return exception_set_number;
      if (extCtrlModePresent)
         return eic;
      if (!vectoredModePresent)
         return exception_set_number;
      return map[vectorIndex * 4 +: 4];
   endfunction

   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One register access; read data is settled by the next falling edge
   task automatic acc(logic wr, logic [1:0] sel, logic [31:0] d);
      @(negedge clk_sys);
      regWrEn = wr;
      regRdEn = !wr;
      regSel = sel;
      regWrData = d;
      @(negedge clk_sys);
      regWrEn = 1'b0;
      regRdEn = 1'b0;
   endtask

   // Entry or return pulse, debugEntry and entrySetsErl dropped with it
   task automatic pulse(logic ent);
      @(negedge clk_sys);
      excEntry = ent;
      exceptionReturn = !ent;
      @(negedge clk_sys);
      excEntry = 1'b0;
      exceptionReturn = 1'b0;
      debugEntry = 1'b0;
      entrySetsErl = 1'b0;
   endtask

   task automatic give_verdict();
      $display("checks %0d failures %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Watchdog well past the expected run length
   initial begin
      #(40 * 20000);
      n_fail++;
      give_verdict();
   end

   initial begin
      repeat (16) @(negedge clk_sys);
      rstn = 1'b1;
      repeat (3) @(posedge clk_sys);
      acc(0, ssrc_pkg::SEL_CTL, 0);
      chk("ctl reset", regRdData, ctlExp());
      acc(0, ssrc_pkg::SEL_MAP, 0);
      chk("map reset", regRdData, 32'h0);
      $display("test reset done");
      // All ones: reserved, highest and current fields must not move
      acc(1, ssrc_pkg::SEL_CTL, 32'hffffffff);
      exception_set_number = 4'hf;
      previous_set_number = 4'hf;
      acc(0, ssrc_pkg::SEL_CTL, 0);
      chk("ctl ones", regRdData, ctlExp());
      acc(1, 2'h2, 32'hffffffff);
      acc(0, 2'h3, 0);
      chk("unmapped", regRdData, 32'h0);
      map = 32'h3a3a3a3a;                              // Shared sets
      acc(1, ssrc_pkg::SEL_MAP, map);
      acc(0, ssrc_pkg::SEL_MAP, 0);
      chk("map shared", regRdData, map);
      $display("test corners done");
      for (i = 0; i < 300; i++) begin
         r = $random(seed);
         errorLevelFlag = r[3:0] == 4'h1;
         exceptionLevelFlag = r[3:0] == 4'h2;
         bootVectorSelect = r[3:0] == 4'h3;
         entrySetsErl = r[3:0] == 4'h4;
         debugEntry = r[3:0] == 4'h5;
         entryIsIntr = r[4];
         interruptVectorSelect = r[5];
         extCtrlModePresent = r[12];
         vectorSpacing = (r[6] && !r[12]) ? 5'h0 : {r[10:7], 1'b1};
         vectoredModePresent = r[13] | r[22];
         vectorIndex = r[16:14];
         r2 = $random(seed);
         if (i % 4 == 0) begin
            acc(1, ssrc_pkg::SEL_CTL, r2);
            exception_set_number = r2[15:12];
            previous_set_number = r2[9:6];
         end
         if (i % 8 == 1) begin
            map = r2;
            acc(1, ssrc_pkg::SEL_MAP, map);
         end
         if (r[12]) begin
            @(negedge clk_sys);
            go = 1'b1;
            setVal = r[20:17];
            @(negedge clk_sys);
            go = 1'b0;
            eic = r[20:17];
         end
         if (r[21]) begin
            if (r[3:0] == 4'h0 || r[3:0] > 4'h5) begin
               previous_set_number = current_set_number;
               current_set_number = newSet();
            end
            pulse(1);
         end else begin
            if (!errorLevelFlag && !bootVectorSelect)
               current_set_number = previous_set_number;
            pulse(0);
         end
         chk("currentSet", {28'h0, currentSet}, {28'h0, current_set_number});
         acc(0, ssrc_pkg::SEL_CTL, 0);
         chk("ctl", regRdData, ctlExp());
      end
      acc(0, ssrc_pkg::SEL_MAP, 0);
      chk("map", regRdData, map);
      $display("test random done");
      give_verdict();
   end
endmodule // ssrc_ctrl_tb
